// ===== hdl/cfp_defines.vh
/*
 upper configuration-byte map, field positions, unprogrammed values
 and protection address ranges for the fuse decode block.
 assumes 22-bit table addresses and byte-wide configuration cells.
*/
`ifndef CFP_DEFINES_VH
`define CFP_DEFINES_VH

// configuration byte addresses
`define CFP_ADDR_PIN_RST 22'h300005
`define CFP_ADDR_DBG_CORE 22'h300006
`define CFP_ADDR_BLK_CODE 22'h300008
`define CFP_ADDR_BOOT_CODE 22'h300009
`define CFP_ADDR_BLK_WR 22'h30000a
`define CFP_ADDR_BOOT_WR 22'h30000b
`define CFP_ADDR_BLK_TRD 22'h30000c
`define CFP_ADDR_BOOT_TRD 22'h30000d
`define CFP_CFG_BASE 22'h300000
`define CFP_CFG_LAST 22'h3000ff
`define CFP_CFG_SPACE_HI 2'h3

// implemented-bit masks; other bits read zero
`define CFP_MASK_PIN_RST 8'h87
`define CFP_MASK_DBG_CORE 8'hc5
`define CFP_MASK_BLK 8'h0f
`define CFP_MASK_BOOT_CODE 8'hc0
`define CFP_MASK_BOOT_WR 8'he0
`define CFP_MASK_BOOT_TRD 8'h40

// unprogrammed values
`define CFP_RST_PIN_RST 8'h83
`define CFP_RST_DBG_CORE 8'h85
`define CFP_RST_BLK 8'h0f
`define CFP_RST_BOOT_CODE 8'hc0
`define CFP_RST_BOOT_WR 8'he0
`define CFP_RST_BOOT_TRD 8'h40

// field positions
`define CFP_BIT_RST_PIN_SEL 7
`define CFP_BIT_OSC_LP 2
`define CFP_BIT_PB_ANALOG 1
`define CFP_BIT_CC2_ROUTE 0
`define CFP_BIT_DEBUG 7
`define CFP_BIT_EXTENDED_INSTRUCTION_ENABLE 6
`define CFP_BIT_LVP 2
`define CFP_BIT_STK_RST 0
`define CFP_BIT_EE_GUARD 7
`define CFP_BIT_BOOT_GUARD 6
`define CFP_BIT_CFG_WR 5
`define CFP_BIT_BOOT_TRD 6

// program memory layout
`define CFP_BOOT_LAST 22'h0007ff
`define CFP_BLK_LAST 22'h007fff
`define CFP_BLK_SHIFT 13
`define CFP_BLOCKED_DATA 8'h00
`define CFP_ADC_PB_ANALOG 4'h0
`define CFP_ADC_PB_DIGITAL 4'hf

`endif

// ===== hdl/cfp_fuse_guard.v
/*
 configuration fuse decode and program-memory protection checks.
 assumes fuse cells are modelled as flops reset to unprogrammed values
 (power-on), table accesses arrive as one-cycle strobes, and the
 owning memory controllers honour the allow/refuse outputs.
*/
// Functional notes
// - select one: pin is external reset; zero: plain port-E input
// - oscillator low-power fuse one selects low-power secondary oscillator
// - analog default fuse sets port-B lines 4..0 analog at reset
// - capture/compare-2 routed to port-C line one or port-B three
// - debug fuse zero reserves port-B six and seven for debug
// - extended fuse one enables instruction extension and indexed mode
// - low-voltage programming entry accepted only when its fuse is one
// - stack fault resets device only when its fuse is one
// - code-protect fuse zero protects its program block
// - eeprom code-protect fuse zero protects data eeprom
// - boot code-protect fuse zero protects addresses 0 to 7ff
// - block write-protect fuse zero refuses self-writes to that block
// - eeprom write-protect fuse zero refuses data eeprom writes
// - boot write-protect fuse zero refuses writes to boot block
// - config write-protect fuse zero refuses configuration space writes
// - config write-protect fuse changes only in programming mode
// - block table-read fuse zero refuses reads from other blocks
// - boot table-read fuse zero refuses reads from outside boot
// - protection fuses read one unprogrammed, only clear by writing
// - unimplemented configuration bits read zero
// - programmed bit reads zero, unprogrammed reads one except the oscillator low-power and extended fuses
`timescale 1ns/1ps
`include "cfp_defines.vh"

module cfp_fuse_guard #(
   parameter ADDR_W = 22
) (
   input wire core_clk,
   input wire rst,
   input wire por,
   input wire prog_mode,
   input wire tbl_rd,
   input wire tbl_wr,
   input wire [ADDR_W-1:0] tbl_addr,
   input wire [ADDR_W-1:0] exec_addr,
   input wire [7:0] tbl_wdata,
   input wire [7:0] mem_rdata,
   input wire tbl_wr_eeprom,
   input wire eeprom_rd_ext,
   input wire stack_fault,
   input wire lvp_entry_req,
   input wire external_reset_pin_n,
   output reg [7:0] tbl_rdata_q,
   output reg tbl_rd_done_q,
   output reg tbl_rd_refused_q,
   output reg tbl_wr_done_q,
   output reg tbl_wr_refused_q,
   output reg prog_wr_allow_q,
   output reg eeprom_wr_allow_q,
   output reg external_reset_q,
   output reg porte_line_three_en_q,
   output reg porte_line_three_q,
   output reg secondary_osc_low_power_q,
   output reg [3:0] adc_pcfg_reset_q,
   output reg cc2_on_portc_line_one_q,
   output reg cc2_on_port_b_a_line_three_q,
   output reg debug_pins_reserved_q,
   output reg extended_instruction_enable_q,
   output reg lvp_entry_ok_q,
   output reg stack_fault_reset_q,
   output reg [3:0] code_guard_q,
   output reg eeprom_code_guard_q,
   output reg boot_code_guard_q
);

   // fuse cells; only por restores them, like erased non-volatile bits
   reg [7:0] pin_and_reset_options_q;
   reg [7:0] debug_and_core_options_q;
   reg [7:0] block_code_guard_q;
   reg [7:0] boot_and_eeprom_code_guard_q;
   reg [7:0] block_write_guard_q;
   reg [7:0] boot_eeprom_config_write_guard_q;
   reg [7:0] block_table_read_guard_q;
   reg [7:0] boot_table_read_guard_q;

   // controls latched at reset release
   reg [7:0] lat_pin_q;
   reg [7:0] lat_dbg_q;
   reg [3:0] lat_wr_blk_q;
   reg [7:0] lat_wr_boot_q;
   reg [3:0] lat_trd_blk_q;
   reg lat_trd_boot_q;
   reg [3:0] lat_cp_blk_q;
   reg [7:0] lat_cp_boot_q;
   // static control outputs wait one cycle past release so they never see a stale latch
   reg in_rst_q;

   // region of a program address: 0 boot, 1..4 blocks, 7 outside
   function [2:0] region;
      input [ADDR_W-1:0] a;
      begin
         if (a <= `CFP_BOOT_LAST)
            region = 3'h0;
         else if (a <= `CFP_BLK_LAST)
            region = {1'b0, a[`CFP_BLK_SHIFT+1:`CFP_BLK_SHIFT]} + 3'h1;
         else
            region = 3'h7;
      end
   endfunction

   // write-lock bit (zero means locked) for a program region
   function region_wr_ok;
      input [2:0] r;
      begin
         if (r == 3'h0)
            region_wr_ok = lat_wr_boot_q[`CFP_BIT_BOOT_GUARD];
         else if (r == 3'h7)
            region_wr_ok = 1'b1;
         else
            region_wr_ok = lat_wr_blk_q[r[1:0]-2'h1];
      end
   endfunction

   // table-read lock for a region (zero means locked)
   function region_rd_ok;
      input [2:0] r;
      begin
         if (r == 3'h0)
            region_rd_ok = lat_trd_boot_q;
         else if (r == 3'h7)
            region_rd_ok = 1'b1;
         else
            region_rd_ok = lat_trd_blk_q[r[1:0]-2'h1];
      end
   endfunction

   // one-hot select of an option or guard byte; zero for other addresses
   function [7:0] cfg_slot;
      input [ADDR_W-1:0] a;
      begin
         if (a == `CFP_ADDR_PIN_RST)
            cfg_slot = 8'h01;
         else if (a == `CFP_ADDR_DBG_CORE)
            cfg_slot = 8'h02;
         else if (a == `CFP_ADDR_BLK_CODE)
            cfg_slot = 8'h04;
         else if (a == `CFP_ADDR_BOOT_CODE)
            cfg_slot = 8'h08;
         else if (a == `CFP_ADDR_BLK_WR)
            cfg_slot = 8'h10;
         else if (a == `CFP_ADDR_BOOT_WR)
            cfg_slot = 8'h20;
         else if (a == `CFP_ADDR_BLK_TRD)
            cfg_slot = 8'h40;
         else if (a == `CFP_ADDR_BOOT_TRD)
            cfg_slot = 8'h80;
         else
            cfg_slot = 8'h00;
      end
   endfunction

   // whole configuration space, unimplemented bytes included
   wire in_cfg = (tbl_addr[ADDR_W-1:ADDR_W-2] == `CFP_CFG_SPACE_HI);
   wire cfg_low = (tbl_addr >= `CFP_CFG_BASE) &&
      (tbl_addr <= `CFP_CFG_LAST);
   wire [2:0] tgt_region = region(tbl_addr);
   wire [2:0] own_region = region(exec_addr);
   wire cfg_wr_ok = prog_mode |
      lat_wr_boot_q[`CFP_BIT_CFG_WR];
   // the programmer bypasses every lock, as external programming must
   wire prog_wr_ok = prog_mode | region_wr_ok(tgt_region);
   wire ee_wr_ok = prog_mode |
      lat_wr_boot_q[`CFP_BIT_EE_GUARD];
   // code reading its own region is never refused
   wire same_region = (tgt_region == own_region);
   wire rd_ok = prog_mode | same_region |
      region_rd_ok(tgt_region);
   // refusal only for program space; config bytes stay readable
   wire rd_refuse = tbl_rd & ~in_cfg & ~rd_ok;
   wire cfg_wr_hit = tbl_wr & ~tbl_wr_eeprom & in_cfg;
   wire cfg_wr_go = cfg_wr_hit & cfg_low & cfg_wr_ok;
   // in user mode the config write-lock cell is frozen
   wire [7:0] cfgwr_keep = prog_mode ? 8'hff : 8'hdf;
   // readback and cell writes share one decode so they cannot disagree
   wire [7:0] slot = cfg_slot(tbl_addr);

   // write verdict by target; each target class has its own lock bit
   reg wr_ok_c;
   always @*
   begin
      wr_ok_c = 1'b1;
      if (tbl_wr_eeprom)
         wr_ok_c = ee_wr_ok;
      else if (in_cfg)
         wr_ok_c = cfg_low & cfg_wr_ok;
      else
         wr_ok_c = prog_wr_ok;
   end

   // allow strobes to the memory controllers
   wire prog_go = tbl_wr & ~tbl_wr_eeprom & ~in_cfg & prog_wr_ok;
   wire ee_go = tbl_wr & tbl_wr_eeprom & ee_wr_ok;

   // readback mux; unimplemented bits masked to zero
   reg [7:0] cfg_rd;
   always @*
   begin
      cfg_rd = 8'h00;
      if (slot[0])
         cfg_rd = pin_and_reset_options_q & `CFP_MASK_PIN_RST;
      else if (slot[1])
         cfg_rd = debug_and_core_options_q & `CFP_MASK_DBG_CORE;
      else if (slot[2])
         cfg_rd = block_code_guard_q & `CFP_MASK_BLK;
      else if (slot[3])
         cfg_rd = boot_and_eeprom_code_guard_q & `CFP_MASK_BOOT_CODE;
      else if (slot[4])
         cfg_rd = block_write_guard_q & `CFP_MASK_BLK;
      else if (slot[5])
         cfg_rd = boot_eeprom_config_write_guard_q & `CFP_MASK_BOOT_WR;
      else if (slot[6])
         cfg_rd = block_table_read_guard_q & `CFP_MASK_BLK;
      else if (slot[7])
         cfg_rd = boot_table_read_guard_q & `CFP_MASK_BOOT_TRD;
   end

   // fuse cells: option bytes take any value, guards only clear
   // a cleared guard stays cleared until the cells are erased
   always @(posedge core_clk)
   begin
      if (por)
      begin
         pin_and_reset_options_q <= `CFP_RST_PIN_RST;
         debug_and_core_options_q <= `CFP_RST_DBG_CORE;
         block_code_guard_q <= `CFP_RST_BLK;
         boot_and_eeprom_code_guard_q <= `CFP_RST_BOOT_CODE;
         block_write_guard_q <= `CFP_RST_BLK;
         boot_eeprom_config_write_guard_q <= `CFP_RST_BOOT_WR;
         block_table_read_guard_q <= `CFP_RST_BLK;
         boot_table_read_guard_q <= `CFP_RST_BOOT_TRD;
      end
      else if (cfg_wr_go)
      begin
         if (slot[0])
            pin_and_reset_options_q <= tbl_wdata & `CFP_MASK_PIN_RST;
         else if (slot[1])
            debug_and_core_options_q <= tbl_wdata & `CFP_MASK_DBG_CORE;
         else if (slot[2])
            block_code_guard_q <= block_code_guard_q & tbl_wdata;
         else if (slot[3])
            boot_and_eeprom_code_guard_q <=
               boot_and_eeprom_code_guard_q & tbl_wdata;
         else if (slot[4])
            block_write_guard_q <= block_write_guard_q & tbl_wdata;
         else if (slot[5])
            boot_eeprom_config_write_guard_q <=
               boot_eeprom_config_write_guard_q &
               (tbl_wdata | ~cfgwr_keep);
         else if (slot[6])
            block_table_read_guard_q <= block_table_read_guard_q & tbl_wdata;
         else if (slot[7])
            boot_table_read_guard_q <= boot_table_read_guard_q & tbl_wdata;
      end
   end

   // sample fuses while reset is held; frozen once it releases
   // written fuses therefore act only after the next reset
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         in_rst_q <= 1'b1;
         lat_pin_q <= pin_and_reset_options_q;
         lat_dbg_q <= debug_and_core_options_q;
         lat_wr_blk_q <= block_write_guard_q[3:0];
         lat_wr_boot_q <= boot_eeprom_config_write_guard_q;
         lat_trd_blk_q <= block_table_read_guard_q[3:0];
         lat_trd_boot_q <= boot_table_read_guard_q[`CFP_BIT_BOOT_TRD];
         lat_cp_blk_q <= block_code_guard_q[3:0];
         lat_cp_boot_q <= boot_and_eeprom_code_guard_q;
      end
      else
      begin
         in_rst_q <= 1'b0;
      end
   end

   // static control outputs, registered from the latched fuses
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         // quiet defaults while held; the core sits in reset anyway
         external_reset_q <= 1'b0;
         porte_line_three_en_q <= 1'b0;
         porte_line_three_q <= 1'b0;
         secondary_osc_low_power_q <= 1'b0;
         adc_pcfg_reset_q <= `CFP_ADC_PB_ANALOG;
         cc2_on_portc_line_one_q <= 1'b0;
         cc2_on_port_b_a_line_three_q <= 1'b0;
         debug_pins_reserved_q <= 1'b0;
         extended_instruction_enable_q <= 1'b0;
         lvp_entry_ok_q <= 1'b0;
         stack_fault_reset_q <= 1'b0;
         code_guard_q <= 4'h0;
         eeprom_code_guard_q <= 1'b0;
         boot_code_guard_q <= 1'b0;
      end
      else if (!in_rst_q)
      begin
         // reset pin only honoured when selected
         external_reset_q <= lat_pin_q[`CFP_BIT_RST_PIN_SEL] &
            ~external_reset_pin_n;
         // port-E line only carries the pin when the reset role is off
         porte_line_three_en_q <= ~lat_pin_q[`CFP_BIT_RST_PIN_SEL];
         porte_line_three_q <= ~lat_pin_q[`CFP_BIT_RST_PIN_SEL] &
            external_reset_pin_n;
         secondary_osc_low_power_q <= lat_pin_q[`CFP_BIT_OSC_LP];
         adc_pcfg_reset_q <= lat_pin_q[`CFP_BIT_PB_ANALOG] ?
            `CFP_ADC_PB_ANALOG : `CFP_ADC_PB_DIGITAL;
         cc2_on_portc_line_one_q <=
            lat_pin_q[`CFP_BIT_CC2_ROUTE];
         cc2_on_port_b_a_line_three_q <= ~lat_pin_q[`CFP_BIT_CC2_ROUTE];
         debug_pins_reserved_q <= ~lat_dbg_q[`CFP_BIT_DEBUG];
         extended_instruction_enable_q <=
            lat_dbg_q[`CFP_BIT_EXTENDED_INSTRUCTION_ENABLE];
         lvp_entry_ok_q <= lat_dbg_q[`CFP_BIT_LVP] &
            lvp_entry_req;
         stack_fault_reset_q <= lat_dbg_q[`CFP_BIT_STK_RST] &
            stack_fault;
         // protect levels for the memory controllers, one means guarded
         code_guard_q <= ~lat_cp_blk_q;
         eeprom_code_guard_q <= ~lat_cp_boot_q[`CFP_BIT_EE_GUARD];
         boot_code_guard_q <= ~lat_cp_boot_q[`CFP_BIT_BOOT_GUARD];
      end
   end

   // table access answers, one cycle after the strobe
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         tbl_rdata_q <= 8'h00;
         tbl_rd_done_q <= 1'b0;
         tbl_rd_refused_q <= 1'b0;
         tbl_wr_done_q <= 1'b0;
         tbl_wr_refused_q <= 1'b0;
         prog_wr_allow_q <= 1'b0;
         eeprom_wr_allow_q <= 1'b0;
      end
      else
      begin
         tbl_rd_done_q <= tbl_rd;
         tbl_rd_refused_q <= rd_refuse;
         // refused read never exposes protected content
         if (tbl_rd)
            tbl_rdata_q <= in_cfg ? cfg_rd :
               (rd_ok ? mem_rdata : `CFP_BLOCKED_DATA);
         tbl_wr_done_q <= tbl_wr;
         tbl_wr_refused_q <= tbl_wr & ~wr_ok_c;
         // memory commits only on these; a refusal leaves it as it was
         prog_wr_allow_q <= prog_go;
         eeprom_wr_allow_q <= ee_go;
      end
   end

   // eeprom_rd_ext reserved for external read gating by the eeprom unit
   // tied to a local net so the unused input is visibly intentional
   wire unused_ok = eeprom_rd_ext;

endmodule

// ===== testbench/cfp_mem_model.sv
/*
 behavioural program memory behind the guard's table reads.
 assumes content is answered in the same cycle as the address.
*/
`timescale 1ns/1ps
module cfp_mem_model (
   input wire [21:0] tbl_addr,
   output wire [7:0] mem_rdata
);
   // address-derived content, so a refused read cannot pass as real data unless that content is 00
   assign mem_rdata = tbl_addr[7:0] ^ tbl_addr[15:8] ^ 8'h5a;
endmodule

// ===== testbench/cfp_fuse_guard_props.sv
/*
 port assertions for the fuse guard.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module cfp_fuse_guard_props #(
   parameter ADDR_W = 22
) (
   input wire core_clk,
   input wire rst,
   input wire prog_mode,
   input wire tbl_rd,
   input wire tbl_wr,
   input wire [ADDR_W-1:0] tbl_addr,
   input wire [ADDR_W-1:0] exec_addr,
   input wire [7:0] mem_rdata,
   input wire tbl_wr_eeprom,
   input wire stack_fault,
   input wire [7:0] tbl_rdata_q,
   input wire tbl_rd_done_q,
   input wire tbl_rd_refused_q,
   input wire tbl_wr_done_q,
   input wire tbl_wr_refused_q,
   input wire prog_wr_allow_q,
   input wire eeprom_wr_allow_q,
   input wire porte_line_three_q,
   input wire external_reset_q,
   input wire porte_line_three_en_q,
   input wire cc2_on_portc_line_one_q,
   input wire cc2_on_port_b_a_line_three_q,
   input wire stack_fault_reset_q
);
   logic [1:0] age_q;
   // cycles since reset release; static controls settle late
   always @(posedge core_clk)
   begin
      if (rst)
         age_q <= 2'h0;
      else if (age_q != 2'h3)
         age_q <= age_q + 2'h1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_rd_done;
      tbl_rd |=> tbl_rd_done_q;
   endproperty
   a_rd_done: assert property (p_rd_done)
      else $error("read unanswered");
   property p_rd_blank;
      tbl_rd_refused_q |-> tbl_rd_done_q && tbl_rdata_q == 8'h00;
   endproperty
   a_rd_blank: assert property (p_rd_blank)
      else $error("refused read leaks");
   property p_wr_answer;
      tbl_wr |=> tbl_wr_done_q || tbl_wr_refused_q;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write unanswered");
   property p_prog_bypass;
      tbl_wr && prog_mode && !tbl_wr_eeprom
      && tbl_addr < 22'h008000 |=> !tbl_wr_refused_q;
   endproperty
   a_prog_bypass: assert property (p_prog_bypass)
      else $error("programmer refused");
   property p_same_block;
      tbl_rd && tbl_addr >= 22'h000800 && tbl_addr < 22'h008000
      && exec_addr >= 22'h000800 && exec_addr < 22'h008000
      && tbl_addr[14:13] == exec_addr[14:13]
      |=> !tbl_rd_refused_q && tbl_rdata_q == $past(mem_rdata);
   endproperty
   a_same_block: assert property (p_same_block)
      else $error("own block read refused");
   property p_route;
      age_q[1] |-> cc2_on_portc_line_one_q != cc2_on_port_b_a_line_three_q;
   endproperty
   a_route: assert property (p_route)
      else $error("capture pin routed twice");
   property p_pin_share;
      age_q[1] |-> !(porte_line_three_en_q && external_reset_q);
   endproperty
   a_pin_share: assert property (p_pin_share)
      else $error("pin has two roles");
   property p_hold;
      age_q == 2'h3 |-> $stable({cc2_on_portc_line_one_q,
      cc2_on_port_b_a_line_three_q, porte_line_three_en_q});
   endproperty
   a_hold: assert property (p_hold)
      else $error("static control moved");
   property p_stack;
      stack_fault_reset_q |-> $past(stack_fault);
   endproperty
   a_stack: assert property (p_stack)
      else $error("reset without stack fault");
   property p_wr_allow;
      tbl_wr && !tbl_wr_eeprom && tbl_addr < 22'h008000
      |=> prog_wr_allow_q != tbl_wr_refused_q;
   endproperty
   a_wr_allow: assert property (p_wr_allow)
      else $error("program write both allowed and refused");
   property p_ee_allow;
      tbl_wr && tbl_wr_eeprom |=> eeprom_wr_allow_q != tbl_wr_refused_q;
   endproperty
   a_ee_allow: assert property (p_ee_allow)
      else $error("eeprom write both allowed and refused");
   property p_porte;
      porte_line_three_q |-> porte_line_three_en_q;
   endproperty
   a_porte: assert property (p_porte)
      else $error("port-E input seen while reset role active");
   c_rd_refused: cover property (tbl_rd_refused_q);
   c_wr_refused: cover property (tbl_wr_refused_q);
   c_wr_allowed: cover property (prog_wr_allow_q);
endmodule
bind cfp_fuse_guard cfp_fuse_guard_props #(.ADDR_W(ADDR_W))
   cfp_fuse_guard_props_inst (.*);

// ===== testbench/testbench.sv
/*
 self-checking bench: fuse bytes, static controls, access protection.
 assumes cfp_mem_model answers table reads in the request cycle.
*/
`timescale 1ns/1ps
module testbench;
   logic core_clk = 1'b0, rst = 1'b1, por = 1'b1, prog_mode = 1'b0;
   logic tbl_rd = 1'b0, tbl_wr = 1'b0, tbl_wr_eeprom = 1'b0;
   logic eeprom_rd_ext = 1'b0, stack_fault = 1'b1, lvp_entry_req = 1'b1;
   logic external_reset_pin_n = 1'b0;
   logic [21:0] tbl_addr = 22'h000000, exec_addr = 22'h000000, ra;
   logic [7:0] tbl_wdata = 8'h00;
   wire [7:0] mem_rdata, tbl_rdata_q;
   wire [3:0] adc_pcfg_reset_q, code_guard_q;
   wire tbl_rd_done_q, tbl_rd_refused_q, tbl_wr_done_q, tbl_wr_refused_q;
   wire prog_wr_allow_q, eeprom_wr_allow_q, external_reset_q;
   wire porte_line_three_en_q, porte_line_three_q, lvp_entry_ok_q;
   wire secondary_osc_low_power_q, cc2_on_portc_line_one_q;
   wire cc2_on_port_b_a_line_three_q, debug_pins_reserved_q;
   wire extended_instruction_enable_q, stack_fault_reset_q;
   wire eeprom_code_guard_q, boot_code_guard_q;
   logic [9:0] notes[$];
   logic [15:0] lf = 16'h7d18;
   int fails = 0, checks_done = 0, cyc = 0;
   cfp_fuse_guard cfp_fuse_guard_inst (.*);
   cfp_mem_model cfp_mem_model_inst (.*);
   always #10 core_clk = ~core_clk;
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [7:0] mem_of(input logic [21:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // request held one edge; the next call drives after that edge
   task automatic op(input logic r, w, e, input logic [21:0] a, x,
      input logic [7:0] d, input logic rf, input logic [7:0] ed);
      @(posedge core_clk);
      #1;
      tbl_rd = r;
      tbl_wr = w;
      tbl_wr_eeprom = e;
      tbl_addr = a;
      exec_addr = x;
      tbl_wdata = d;
      notes.push_back({r, rf, ed});
   endtask
   task automatic wr(input logic [21:0] a, input logic [7:0] d,
      input logic rf);
      op(1'b0, 1'b1, 1'b0, a, 22'h002000, d, rf, 8'h00);
   endtask
   task automatic rd(input logic [21:0] a, x, input logic rf,
      input logic [7:0] ed);
      op(1'b1, 1'b0, 1'b0, a, x, 8'h00, rf, ed);
   endtask
   task automatic idle;
      @(posedge core_clk);
      #1;
      tbl_rd = 1'b0;
      tbl_wr = 1'b0;
   endtask
   task automatic do_reset(input logic p);
      @(posedge core_clk);
      #1;
      rst = 1'b1;
      por = p;
      repeat (16) @(posedge core_clk);
      #1;
      rst = 1'b0;
      por = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask
   // all eight option and guard bytes, back to back
   task automatic read_all(input logic [63:0] t);
      for (int i = 0; i < 8; i++)
         rd(22'h300005 + 22'(i + (i > 1)), 22'h0, 1'b0, t[63-8*i -: 8]);
      idle;
   endtask
   task automatic statics(input logic [18:0] e);
      chk({external_reset_q, porte_line_three_en_q, secondary_osc_low_power_q,
         adc_pcfg_reset_q, cc2_on_portc_line_one_q, cc2_on_port_b_a_line_three_q,
         debug_pins_reserved_q, extended_instruction_enable_q, lvp_entry_ok_q,
         stack_fault_reset_q, code_guard_q, eeprom_code_guard_q,
         boot_code_guard_q}, e);
   endtask
   // answers pair with the oldest note; a surplus answer never matches
   always @(negedge core_clk)
   begin
      if (tbl_rd_done_q === 1'b1 || tbl_wr_done_q === 1'b1 ||
         tbl_wr_refused_q === 1'b1)
         chk({9'h0, tbl_rd_done_q,
            tbl_rd_done_q ? tbl_rd_refused_q : tbl_wr_refused_q,
            tbl_rd_done_q ? tbl_rdata_q : 8'h00},
            notes.size() ? {9'h0, notes.pop_front()} : 19'h7ffff);
   end
   // hang guard, far above the hundred or so cycles needed
   always @(posedge core_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 4000)
      begin
         fails = fails + 1;
         summarize();
      end
   end
   initial
   begin
      do_reset(1'b1);
      statics(19'h408c0);
      read_all(64'h83850fc00fe00f40);
      wr(22'h300005, 8'h7c, 1'b0);
      wr(22'h300006, 8'h7a, 1'b0);
      wr(22'h300008, 8'h0a, 1'b0);
      idle;
      wr(22'h300008, 8'h0f, 1'b0);
      wr(22'h300009, 8'h3f, 1'b0);
      wr(22'h30000a, 8'hfe, 1'b0);
      wr(22'h30000c, 8'h0b, 1'b0);
      wr(22'h30000d, 8'h00, 1'b0);
      wr(22'h30000b, 8'h00, 1'b0);
      idle;
      rd(22'h30000b, 22'h0, 1'b0, 8'h20);
      idle;
      prog_mode = 1'b1;
      wr(22'h30000b, 8'h00, 1'b0);
      idle;
      prog_mode = 1'b0;
      read_all(64'h04400a000e000b00);
      external_reset_pin_n = 1'b1;
      do_reset(1'b0);
      statics(19'h3f717);
      chk(19'(porte_line_three_q), 19'h1);
      wr(22'h000900, 8'h11, 1'b1);
      wr(22'h002100, 8'h22, 1'b0);
      wr(22'h000100, 8'h33, 1'b1);
      op(1'b0, 1'b1, 1'b1, 22'h000010, 22'h002000, 8'h44, 1'b1,
         8'h00);
      wr(22'h300005, 8'h87, 1'b1);
      idle;
      rd(22'h300005, 22'h0, 1'b0, 8'h04);
      lf = lfsr_next(lf);
      ra = {14'h0040, lf[7:0]};
      rd(ra, 22'h000900, 1'b1, 8'h00);
      rd(ra, 22'h004200, 1'b0, mem_of(ra));
      rd(22'h000100, 22'h002000, 1'b1, 8'h00);
      rd(22'h000100, 22'h000200, 1'b0, mem_of(22'h000100));
      ra = {14'h0020, lf[15:8]};
      rd(ra, 22'h004000, 1'b0, mem_of(ra));
      idle;
      prog_mode = 1'b1;
      wr(22'h000900, 8'h55, 1'b0);
      idle;
      prog_mode = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      external_reset_pin_n = 1'b0;
      do_reset(1'b1);
      statics(19'h408c0);
      chk(19'(notes.size()), 19'h0);
      summarize();
   end
endmodule
